// [tacs_alert.sv]
// Alert, critical output and alert-response logic with APB registers
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [R1] Compare each conversion against high, critical, low
// [R2] Alert asserts only while mask bit clear
// [R3] Alert and critical outputs active-low open-drain
// [R4] Comparator mode releases alert when condition ends
// [R5] Comparator mode bit selects it, clear at reset
// [R6] Interrupt mode when comparator bit low
// [R7] Status read in interrupt mode sets mask
// [R8] Status read clears; next conversion sets again
// [R9] Mask set keeps alert released until cleared
// [R10] Host reads status then clears mask
// [R11] Host issues alert response read, NACK, STOP
// [R12] Alerting device acknowledges, sends address, checks bits
// [R13] Full address sent: release alert, set mask
// [R14] Bit mismatch: stop driving, keep alert, leave mask unchanged
// [R15] Answer response only when alert-config bit low
// [R16] Mask and alert-config low after reset
// [R17] Alert only pulls low, never drives high
// [R18] Critical output follows remote critical status bit
// [R19] Critical clears at setpoint minus hysteresis
// [R20] Critical setpoint locked until override bit set
// [R21] Unsigned-format bit selects setpoint coding, wide range; code uses it for critical and remote high setpoints only
// [R22] Bus clock input only; data bidirectional
// [R23] Fixed slave address 1001100, MSB first
module tacs_alert (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic conv_done, // One-cycle pulse at conversion end
	input wire logic [7:0] local_temperature, // Local reading, signed deg C
	input wire logic [8:0] remote_temp, // Remote reading, signed deg C
	input wire logic conv_busy, // Converter busy level
	input wire logic diode_fault, // Remote diode fault level
	input wire logic scl_i, // Bus clock line level
	input wire logic sda_i, // Bus data line level
	output logic sda_o, // Bus data drive value, always low
	output logic sda_oe, // Bus data pull-down enable
	output logic alert_n_o, // Alert drive value, always low
	output logic alert_oe, // Alert pull-down enable
	output logic critical_temp_n_o, // Critical drive value, always low
	output logic critical_temp_oe // Critical pull-down enable
);
	tacs_pkg::tacs_state_t q_r, q_nxt;

	// Setpoint as signed 10-bit, coded signed or unsigned
	function automatic logic signed [9:0] sp_ext(input logic [7:0] sp,
			input logic uns);
		sp_ext = uns ? {2'b00, sp} : {{2{sp[7]}}, sp};
	endfunction

	logic signed [9:0] remote_ext;
	logic signed [9:0] crit_ext;
	logic signed [9:0] crit_low;
	logic acc_done;
	logic [7:0] ofs;
	logic scl_rise, scl_fall, bus_start, bus_stop, line;
	logic [7:0] clr_mask;
	logic [7:0] set_bits;

	always_comb begin
		remote_ext = {remote_temp[8], remote_temp};
		crit_ext = sp_ext(q_r.crit_sp, q_r.unsigned_format_select); // R21
		crit_low = crit_ext - $signed({2'b00, q_r.hyst}); // R19
		acc_done = psel && penable && q_r.pready;
		ofs = paddr[7:0];
		scl_rise = q_r.scl_s[1] && !q_r.scl_s[2];
		scl_fall = !q_r.scl_s[1] && q_r.scl_s[2];
		line = q_r.sda_s[1];
		bus_start = q_r.scl_s[1] && q_r.scl_s[2] && !line && q_r.sda_s[2];
		bus_stop = q_r.scl_s[1] && q_r.scl_s[2] && line && !q_r.sda_s[2];
	end

	always_comb begin
		q_nxt = q_r;
		clr_mask = 8'h00;
		set_bits = 8'h00;
		// Two-flop synchronisers for the bus lines
		q_nxt.scl_s = {q_r.scl_s[1:0], scl_i}; // R22
		q_nxt.sda_s = {q_r.sda_s[1:0], sda_i};

		// APB: one wait state, effects at the completing edge
		q_nxt.pready = psel && penable && !q_r.pready;
		if (psel && penable && !q_r.pready) begin
			q_nxt.prdata = 32'h0000_0000;
			q_nxt.pslverr = 1'b0;
			case (ofs)
			tacs_pkg::OFS_CONFIG: begin
				q_nxt.prdata[tacs_pkg::CFG_MASK_BIT] = q_r.mask;
				q_nxt.prdata[tacs_pkg::CFG_OVR_BIT] = q_r.ovr;
			end
			tacs_pkg::OFS_MODE: begin
				q_nxt.prdata[tacs_pkg::MODE_CMP_BIT] = q_r.cmp_mode;
				q_nxt.prdata[tacs_pkg::MODE_ACFG_BIT] = q_r.alert_cfg;
			end
			tacs_pkg::OFS_ENHCFG: q_nxt.prdata[tacs_pkg::ENH_USF_BIT] = q_r.unsigned_format_select;
			tacs_pkg::OFS_STATUS: q_nxt.prdata[7:0] = q_r.stat;
			tacs_pkg::OFS_CRIT: q_nxt.prdata[7:0] = q_r.crit_sp;
			tacs_pkg::OFS_HYST: q_nxt.prdata[7:0] = q_r.hyst;
			tacs_pkg::OFS_LHS: q_nxt.prdata[7:0] = q_r.local_high_setpoint;
			tacs_pkg::OFS_RHS: q_nxt.prdata[7:0] = q_r.rhs;
			tacs_pkg::OFS_RLS: q_nxt.prdata[7:0] = q_r.rls;
			default: q_nxt.pslverr = 1'b1;
			endcase
			if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'b00) begin
				q_nxt.pslverr = 1'b1;
				q_nxt.prdata = 32'h0000_0000;
			end
		end

		if (acc_done && !q_r.pslverr) begin
			if (pwrite) begin
				case (ofs)
				tacs_pkg::OFS_CONFIG: begin
					q_nxt.mask = pwdata[tacs_pkg::CFG_MASK_BIT]; // R10
					q_nxt.ovr = pwdata[tacs_pkg::CFG_OVR_BIT];
				end
				tacs_pkg::OFS_MODE: begin
					q_nxt.cmp_mode = pwdata[tacs_pkg::MODE_CMP_BIT]; // R5
					q_nxt.alert_cfg = pwdata[tacs_pkg::MODE_ACFG_BIT];
				end
				tacs_pkg::OFS_ENHCFG: q_nxt.unsigned_format_select = pwdata[tacs_pkg::ENH_USF_BIT];
				tacs_pkg::OFS_CRIT: begin
					if (q_r.ovr) begin
						q_nxt.crit_sp = pwdata[7:0]; // R20
					end
				end
				tacs_pkg::OFS_HYST: q_nxt.hyst = pwdata[7:0];
				tacs_pkg::OFS_LHS: q_nxt.local_high_setpoint = pwdata[7:0];
				tacs_pkg::OFS_RHS: q_nxt.rhs = pwdata[7:0];
				tacs_pkg::OFS_RLS: q_nxt.rls = pwdata[7:0];
				default: q_nxt.unsigned_format_select = q_r.unsigned_format_select;
				endcase
			end else if (ofs == tacs_pkg::OFS_STATUS) begin
				clr_mask = tacs_pkg::CLEAR_BITS; // R8
				if (!q_r.cmp_mode &&
						|(q_r.stat & tacs_pkg::ALERT_BITS)) begin
					q_nxt.mask = 1'b1; // R6 R7
				end
			end
		end

		// Conversion end: limit checks; a set beats a same-cycle clear
		if (conv_done) begin
			set_bits[tacs_pkg::ST_LHIGH] =
				$signed(local_temperature) > $signed(q_r.local_high_setpoint); // R1
			set_bits[tacs_pkg::ST_RHIGH] =
				remote_ext > sp_ext(q_r.rhs, q_r.unsigned_format_select); // R1 R21
			set_bits[tacs_pkg::ST_RLOW] =
				remote_ext < sp_ext(q_r.rls, 1'b0); // R1
			set_bits[tacs_pkg::ST_FAULT] = diode_fault;
			q_nxt.cond = {set_bits[tacs_pkg::ST_RHIGH],
				set_bits[tacs_pkg::ST_RLOW], set_bits[tacs_pkg::ST_LHIGH]};
		end
		q_nxt.stat = (q_r.stat & ~clr_mask) | set_bits; // R8
		q_nxt.stat[tacs_pkg::ST_BUSY] = conv_busy;
		// Critical status follows its own hysteresis band
		if (conv_done) begin
			if (remote_ext > crit_ext) begin
				q_nxt.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS] = 1'b1; // R18
			end else if (remote_ext <= crit_low) begin
				q_nxt.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS] = 1'b0; // R19
			end else begin
				q_nxt.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS] = q_r.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS];
			end
			if (remote_ext > crit_ext) begin
				q_nxt.cond[0] = 1'b1; // R1
			end
		end

		// Alert-response link
		case (q_r.st)
		tacs_pkg::TACS_IDLE: q_nxt.sda_oe = 1'b0;
		tacs_pkg::TACS_ADDR: begin
			if (scl_rise) begin
				q_nxt.shreg = {q_r.shreg[6:0], line};
				q_nxt.bitcnt = q_r.bitcnt + 3'h1;
				if (q_r.bitcnt == tacs_pkg::LAST_BIT) begin
					if ({q_r.shreg[6:0], line} ==
							{tacs_pkg::ARA_ADDR, 1'b1} &&
							q_r.alert_oe && !q_r.alert_cfg) begin
						q_nxt.st = tacs_pkg::TACS_ACK; // R12 R15
					end else begin
						q_nxt.st = tacs_pkg::TACS_IDLE;
					end
				end
			end
		end
		tacs_pkg::TACS_ACK: begin
			if (scl_fall) begin
				if (!q_r.sda_oe) begin
					q_nxt.sda_oe = 1'b1; // R12
				end else begin
					q_nxt.shreg = {tacs_pkg::SLAVE_ADDR, 1'b0}; // R23
					q_nxt.sda_oe = !tacs_pkg::SLAVE_ADDR[6];
					q_nxt.bitcnt = 3'h0;
					q_nxt.st = tacs_pkg::TACS_TX;
				end
			end
		end
		tacs_pkg::TACS_TX: begin
			if (scl_rise) begin
				if (line != q_r.shreg[7]) begin
					q_nxt.sda_oe = 1'b0; // R14
					q_nxt.st = tacs_pkg::TACS_IDLE;
				end else if (q_r.bitcnt == tacs_pkg::LAST_BIT) begin
					q_nxt.mask = 1'b1; // R13
					q_nxt.st = tacs_pkg::TACS_DONE;
				end else begin
					q_nxt.bitcnt = q_r.bitcnt + 3'h1;
				end
			end else if (scl_fall) begin
				q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
				q_nxt.sda_oe = !q_r.shreg[6]; // R12
			end
		end
		tacs_pkg::TACS_DONE: begin
			if (scl_fall) begin
				q_nxt.sda_oe = 1'b0;
				q_nxt.st = tacs_pkg::TACS_IDLE;
			end
		end
		default: q_nxt.st = tacs_pkg::TACS_IDLE;
		endcase
		if (bus_start) begin
			q_nxt.st = tacs_pkg::TACS_ADDR;
			q_nxt.bitcnt = 3'h0;
			q_nxt.sda_oe = 1'b0;
		end else if (bus_stop) begin
			q_nxt.st = tacs_pkg::TACS_IDLE;
			q_nxt.sda_oe = 1'b0;
		end

		// Alert pull-down
		if (q_nxt.mask) begin
			q_nxt.alert_oe = 1'b0; // R2 R9 R16
		end else if (q_nxt.cmp_mode) begin
			q_nxt.alert_oe = |q_nxt.cond; // R4 R5
		end else begin
			q_nxt.alert_oe = |(q_nxt.stat & tacs_pkg::ALERT_BITS); // R6
		end
		q_nxt.critical_temp_output_oe = q_nxt.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS]; // R18
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
				mask: 1'b0, ovr: 1'b0, cmp_mode: 1'b0, alert_cfg: 1'b0,
				unsigned_format_select: 1'b0, crit_sp: tacs_pkg::CRIT_RST,
				hyst: tacs_pkg::HYST_RST, local_high_setpoint: tacs_pkg::LHS_RST,
				rhs: tacs_pkg::RHS_RST, rls: tacs_pkg::RLS_RST,
				stat: 8'h00, cond: 3'h0, alert_oe: 1'b0, critical_temp_output_oe: 1'b0,
				sda_oe: 1'b0, scl_s: 3'h7, sda_s: 3'h7,
				st: tacs_pkg::TACS_IDLE, bitcnt: 3'h0,
				shreg: 8'h00}; // R16
		end else begin
			q_r <= q_nxt;
		end
	end

	// Open-drain pins: value fixed low, only the enables move
	assign prdata = q_r.prdata;
	assign pready = q_r.pready;
	assign pslverr = q_r.pslverr;
	assign sda_o = 1'b0; // R22
	assign sda_oe = q_r.sda_oe;
	assign alert_n_o = 1'b0; // R3 R17
	assign alert_oe = q_r.alert_oe;
	assign critical_temp_n_o = 1'b0; // R3
	assign critical_temp_oe = q_r.critical_temp_output_oe;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	mask_blocks_alert_a: assert property (q_r.mask |-> !alert_oe) // R2
		else $error("alert driven while masked");
	crit_follows_a: assert property ( // R18
		critical_temp_oe == q_r.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS])
		else $error("critical output differs from status");
	stat_read_mask_a: assert property (acc_done && !pwrite && // R7
		!pslverr && ofs == tacs_pkg::OFS_STATUS && !q_r.cmp_mode &&
		|(q_r.stat & tacs_pkg::ALERT_BITS) |=> q_r.mask)
		else $error("status read did not set mask");
	// A read that finds no alert bit leaves the mask alone
	fault_no_mask_a: assert property (acc_done && !pwrite && // R7
		!pslverr && ofs == tacs_pkg::OFS_STATUS &&
		(q_r.stat & tacs_pkg::ALERT_BITS) == 8'h00 &&
		q_r.st != tacs_pkg::TACS_TX |=> q_r.mask == $past(q_r.mask))
		else $error("status read without alert bits set mask");
	status_clear_a: assert property (acc_done && !pwrite && // R8
		!pslverr && ofs == tacs_pkg::OFS_STATUS && !conv_done
		|=> (q_r.stat & tacs_pkg::CLEAR_BITS) == 8'h00)
		else $error("status read left clearable bits set");
	crit_locked_a: assert property (!q_r.ovr |=> $stable(q_r.crit_sp)) // R20
		else $error("critical setpoint changed while locked");
	cmp_release_a: assert property (q_r.cmp_mode && !q_r.mask && // R4
		q_r.cond == 3'h0 |-> !alert_oe)
		else $error("comparator alert held without condition");
	// Interrupt mode: alert mirrors the status bits in ALERT_BITS
	irq_level_a: assert property (!q_r.cmp_mode && !q_r.mask |-> // R6
		alert_oe == |(q_r.stat & tacs_pkg::ALERT_BITS))
		else $error("interrupt alert differs from status");
	// Local limit checked by a compare of its own
	lhigh_set_a: assert property (conv_done && // R1
		$signed(local_temperature) > $signed(q_r.local_high_setpoint)
		|=> q_r.stat[tacs_pkg::ST_LHIGH])
		else $error("local high status not set");
	// The data pull-down is only active inside a response
	sda_idle_a: assert property (q_r.st == tacs_pkg::TACS_IDLE // R22
		|-> !sda_oe)
		else $error("data line driven while idle");
	crit_set_a: assert property (conv_done && remote_ext > crit_ext // R1
		|=> q_r.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS] ##1 critical_temp_oe)
		else $error("critical status not set above setpoint");
	crit_clear_a: assert property (conv_done && remote_ext <= crit_low // R19
		&& remote_ext <= crit_ext |=> !q_r.stat[tacs_pkg::ST_REMOTE_CRITICAL_STATUS])
		else $error("critical status not cleared below band");
	// Alert-config high keeps the response from acknowledging
	ara_gate_a: assert property (q_r.st == tacs_pkg::TACS_ADDR && // R15
		$past(q_r.st) == tacs_pkg::TACS_ADDR && q_r.alert_cfg
		|-> q_r.st != tacs_pkg::TACS_ACK ##1 q_r.st != tacs_pkg::TACS_ACK)
		else $error("response answered with alert-config set");
	ara_done_mask_a: assert property (q_r.st == tacs_pkg::TACS_TX && // R13
		q_nxt.st == tacs_pkg::TACS_DONE |=> q_r.mask && !alert_oe)
		else $error("mask not set after address sent");
	lost_release_a: assert property (q_r.st == tacs_pkg::TACS_TX && // R14
		scl_rise && line != q_r.shreg[7] |=> !sda_oe
		&& q_r.mask == $past(q_r.mask))
		else $error("arbitration loss kept driving");
endmodule // tacs_alert

`default_nettype wire

// [tacs_host.sv]
// Management bus host that runs one alert response read
`timescale 1ns/1ns
`default_nettype none
module tacs_host (
	input wire logic go, // Start one transfer on a rising edge
	input wire logic clash, // Pull data low in the first reply bit
	input wire logic sda, // Resolved data line level
	output logic scl, // Bus clock, held high outside frames
	output logic sda_pull, // High while the host pulls data low
	output logic done, // High when no transfer is running
	output logic nack_seen, // Address byte was not acknowledged
	output logic [7:0] rx // Byte returned by the responder
);
	// Long low phase leaves room for the responder's sampling delay
	task automatic bit_cycle(input logic b, output logic s);
		#10 sda_pull = !b;
		#50 scl = 1'b1;
		#10 s = sda;
		#10 scl = 1'b0;
	endtask

	// One process drives every output: idle levels, then a frame per go
	initial begin : xfer
		logic s;
		logic [7:0] addr;
		scl = 1'b1;
		sda_pull = 1'b0;
		done = 1'b1;
		nack_seen = 1'b0;
		rx = 8'h00;
		addr = {tacs_pkg::ARA_ADDR, 1'b1};
		forever begin
			@(posedge go);
			done = 1'b0;
			#7 sda_pull = 1'b1;
			#60 scl = 1'b0;
			for (int i = 7; i >= 0; i--) begin
				bit_cycle(addr[i], s);
			end
			bit_cycle(1'b1, s);
			nack_seen = s;
			for (int i = 7; i >= 0; i--) begin
				bit_cycle(!(clash && i == 7), s);
				rx[i] = s;
			end
			bit_cycle(1'b1, s);
			#10 sda_pull = 1'b1;
			#50 scl = 1'b1;
			#60 sda_pull = 1'b0;
			#10 done = 1'b1;
		end
	end
endmodule // tacs_host
`default_nettype wire

// [tacs_pkg.sv]
// Package of constants and types for the thermal alert and critical block
package tacs_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_ENHCFG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_CRIT = 8'h10;
	localparam logic [7:0] OFS_HYST = 8'h14;
	localparam logic [7:0] OFS_LHS = 8'h18;
	localparam logic [7:0] OFS_RHS = 8'h1C;
	localparam logic [7:0] OFS_RLS = 8'h20;
	// Field positions
	localparam int CFG_MASK_BIT = 0;
	localparam int CFG_OVR_BIT = 1;
	localparam int MODE_CMP_BIT = 0;
	localparam int MODE_ACFG_BIT = 1;
	localparam int ENH_USF_BIT = 0;
	localparam int ST_LHIGH = 0;
	localparam int ST_RLOW = 1;
	localparam int ST_RHIGH = 2;
	localparam int ST_REMOTE_CRITICAL_STATUS = 3;
	localparam int ST_FAULT = 4;
	localparam int ST_BUSY = 7;
	// Status bits that can raise the alert output
	localparam logic [7:0] ALERT_BITS = 8'h0F;
	// Status bits that a status read clears
	localparam logic [7:0] CLEAR_BITS = 8'h17;
	// Values after reset
	localparam logic [7:0] CRIT_RST = 8'h55;
	localparam logic [7:0] HYST_RST = 8'h0A;
	localparam logic [7:0] LHS_RST = 8'h46;
	localparam logic [7:0] RHS_RST = 8'h46;
	localparam logic [7:0] RLS_RST = 8'h00;
	// Management bus addresses
	localparam logic [6:0] SLAVE_ADDR = 7'h4C;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [2:0] {
		TACS_IDLE = 3'b000,
		TACS_ADDR = 3'b001,
		TACS_ACK = 3'b010,
		TACS_TX = 3'b011,
		TACS_DONE = 3'b100
	} tacs_link_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic mask;
		logic ovr;
		logic cmp_mode;
		logic alert_cfg;
		logic unsigned_format_select;
		logic [7:0] crit_sp;
		logic [7:0] hyst;
		logic [7:0] local_high_setpoint;
		logic [7:0] rhs;
		logic [7:0] rls;
		logic [7:0] stat;
		logic [2:0] cond;
		logic alert_oe;
		logic critical_temp_output_oe;
		logic sda_oe;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		tacs_link_t st;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
	} tacs_state_t;
endpackage

// [testbench.sv]
// Register-level testbench for the alert and critical block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic conv_done = 1'b0;
	logic [7:0] lt = 8'h00;
	logic [8:0] rt = 9'h000;
	logic busy = 1'b0;
	logic fault = 1'b0;
	logic go = 1'b0;
	logic clash = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, sda_o, sda_oe, alert_n_o, alert_oe;
	logic crit_n, crit_oe, scl, host_pull, done, nack, sda_line, serr;
	logic [7:0] rx;
	logic [7:0] ofs [9] = '{tacs_pkg::OFS_CONFIG, tacs_pkg::OFS_MODE,
		tacs_pkg::OFS_ENHCFG, tacs_pkg::OFS_STATUS, tacs_pkg::OFS_CRIT,
		tacs_pkg::OFS_HYST, tacs_pkg::OFS_LHS, tacs_pkg::OFS_RHS,
		tacs_pkg::OFS_RLS};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, tacs_pkg::CRIT_RST,
		tacs_pkg::HYST_RST, tacs_pkg::LHS_RST, tacs_pkg::RHS_RST,
		tacs_pkg::RLS_RST};
	int err_total = 0;
	int n_tests = 0;

	// Pull-up on the data line; either party may pull it low
	assign sda_line = !(host_pull | sda_oe);
	always #5 pclk = ~pclk;

	tacs_alert DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_done(conv_done), .local_temperature(lt), .remote_temp(rt),
		.conv_busy(busy), .diode_fault(fault), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.alert_n_o(alert_n_o), .alert_oe(alert_oe),
		.critical_temp_n_o(crit_n), .critical_temp_oe(crit_oe));

	tacs_host host (.go(go), .clash(clash), .sda(sda_line), .scl(scl),
		.sda_pull(host_pull), .done(done), .nack_seen(nack), .rx(rx));

	task automatic close_out();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			close_out();
		end
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic conv(input logic [7:0] l, input logic [8:0] r);
		lt <= l;
		rt <= r;
		conv_done <= 1'b1;
		@(posedge pclk);
		conv_done <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task automatic ara(input logic c);
		int n;
		n = 0;
		clash <= c;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		do begin
			@(posedge pclk);
			n++;
		end while (done !== 1'b1 && n < 400);
		if (done !== 1'b1) begin
			err_total++;
			close_out();
		end
		repeat (4) @(posedge pclk);
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ofs[i]) rd(ofs[i], {24'h0, rv[i]});
		chk({alert_oe, crit_oe, sda_oe}, 32'h0);
		chk({alert_n_o, crit_n, sda_o}, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(serr, 32'h1);
		$display("Test reset done");
		wr(tacs_pkg::OFS_CRIT, 32'h20);
		rd(tacs_pkg::OFS_CRIT, 32'h55);
		wr(tacs_pkg::OFS_CONFIG, 32'h02);
		wr(tacs_pkg::OFS_CRIT, 32'h20);
		rd(tacs_pkg::OFS_CRIT, 32'h20);
		wr(tacs_pkg::OFS_HYST, 32'h05);
		conv(8'h10, 9'd32);
		chk({alert_oe, crit_oe}, 32'h0);
		conv(8'h10, 9'd33);
		chk({alert_oe, crit_oe}, 32'h3);
		rd(tacs_pkg::OFS_STATUS, 32'h08);
		rd(tacs_pkg::OFS_CONFIG, 32'h03);
		chk(alert_oe, 32'h0);
		conv(8'h10, 9'd28);
		chk({alert_oe, crit_oe}, 32'h1);
		conv(8'h10, 9'd27);
		chk(crit_oe, 32'h0);
		rd(tacs_pkg::OFS_STATUS, 32'h00);
		wr(tacs_pkg::OFS_CONFIG, 32'h02);
		$display("Test critical done");
		wr(tacs_pkg::OFS_ENHCFG, 32'h01);
		wr(tacs_pkg::OFS_CRIT, 32'hC8);
		conv(8'h10, 9'd150);
		chk({alert_oe, crit_oe}, 32'h2);
		conv(8'h10, 9'd201);
		chk(crit_oe, 32'h1);
		conv(8'h10, 9'd20);
		chk(crit_oe, 32'h0);
		rd(tacs_pkg::OFS_STATUS, 32'h04);
		wr(tacs_pkg::OFS_CONFIG, 32'h02);
		wr(tacs_pkg::OFS_ENHCFG, 32'h00);
		wr(tacs_pkg::OFS_CRIT, {24'h0, tacs_pkg::CRIT_RST});
		$display("Test format done");
		wr(tacs_pkg::OFS_MODE, 32'h01);
		conv(8'h50, 9'd20);
		chk(alert_oe, 32'h1);
		conv(8'h10, 9'd20);
		chk(alert_oe, 32'h0);
		wr(tacs_pkg::OFS_MODE, 32'h00);
		chk(alert_oe, 32'h1);
		$display("Test comparator done");
		wr(tacs_pkg::OFS_MODE, 32'h02);
		ara(1'b0);
		chk({nack, alert_oe}, 32'h3);
		wr(tacs_pkg::OFS_MODE, 32'h00);
		ara(1'b1);
		chk({nack, alert_oe}, 32'h1);
		rd(tacs_pkg::OFS_CONFIG, 32'h02);
		ara(1'b0);
		chk({nack, rx}, {24'h0, tacs_pkg::SLAVE_ADDR, 1'b0});
		chk(alert_oe, 32'h0);
		rd(tacs_pkg::OFS_CONFIG, 32'h03);
		rd(tacs_pkg::OFS_STATUS, 32'h01);
		wr(tacs_pkg::OFS_CONFIG, 32'h02);
		$display("Test response done");
		fault <= 1'b1;
		busy <= 1'b1;
		conv(8'h10, 9'd20);
		chk(alert_oe, 32'h0);
		rd(tacs_pkg::OFS_STATUS, 32'h90);
		rd(tacs_pkg::OFS_CONFIG, 32'h02);
		$display("Test fault done");
		close_out();
	end
endmodule // testbench
`default_nettype wire
